// ==== gex_pkg.sv ====
package gex_pkg;

    // ==========================================================
    // register indices, byte address is index times four
    localparam logic [2:0] REG_IN0   = 3'h0;
    localparam logic [2:0] REG_IN1   = 3'h1;
    localparam logic [2:0] REG_OUT0  = 3'h2;
    localparam logic [2:0] REG_OUT1  = 3'h3;
    localparam logic [2:0] REG_POL0  = 3'h4;
    localparam logic [2:0] REG_POL1  = 3'h5;
    localparam logic [2:0] REG_CFG0  = 3'h6;
    localparam logic [2:0] REG_CFG1  = 3'h7;
    localparam logic [5:0] WIDX_STAT = 6'h08;
    localparam logic [5:0] WIDX_MASK = 6'h09;

    // ==========================================================
    // status bit positions
    localparam int STAT_CHG = 0;
    localparam int STAT_WR  = 1;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_DRIVE = 16'h0000;
    localparam logic [15:0] RST_OUT   = 16'hFFFF;
    localparam logic [15:0] RST_POL   = 16'h0000;
    localparam logic        ADDR_TOP  = 1'h0;

    // ==========================================================
    // timing
    localparam int CLK_NS    = 8;
    localparam int FILT_NS   = 50;
    localparam int FILT_CYC  = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FMP_KHZ   = 1000;

    // ==========================================================
    // serial slave states
    typedef enum logic [2:0] {
        GEX_IDLE,
        GEX_ADDR,
        GEX_ACK,
        GEX_RX,
        GEX_TX,
        GEX_MACK
    } gex_i2c_st_t;

endpackage

// ==== gex_sync.sv ====
`timescale 1ns/10ps
module gex_sync #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gex_sync_t;

    gex_sync_t s_q;
    gex_sync_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = i_async;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.s2;
endmodule // gex_sync

// ==== gex_glitch_filt.sv ====
`timescale 1ns/10ps
module gex_glitch_filt (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_line,
    output logic      o_line
);
    localparam logic [3:0] CNT_TOP = 4'(gex_pkg::FILT_CYC - 1);

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       line;
        logic [3:0] cnt;
    } gex_filt_t;

    gex_filt_t s_q;
    gex_filt_t s_d;

    // ==========================================================
    // sync then hold-off filter
    always_comb begin
        s_d    = s_q;
        s_d.s1 = i_line;
        s_d.s2 = s_q.s1;
        if (s_q.s2 == s_q.line) begin
            s_d.cnt = 4'h0;
        end else if (s_q.cnt == CNT_TOP) begin
            s_d.line = s_q.s2;
            s_d.cnt  = 4'h0;
        end else begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '{s1: 1'b1, s2: 1'b1, line: 1'b1, cnt: 4'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_line = s_q.line;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    filter_hold_a: assert property ($changed(o_line) |-> $past(s_q.cnt) == CNT_TOP)
        else $error("filtered line moved before hold-off elapsed");
endmodule // gex_glitch_filt

// ==== gex_expander.sv ====
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - sixteen pins in two byte ports, each with direction, input, output, polarity.
// - after reset all sixteen pins are inputs with drivers off.
// - each pin direction set by its own writable direction bit.
// - input register shows pin levels; output pins driven from output register.
// - set polarity bit returns the complement of the pin on input reads.
// - every register reads back over the bus.
// - alert asserts while any input pin differs from its held input value.
// - alert is active low open drain, only ever pulled low.
// - reset loads all registers with defaults and idles the serial machine.
// - three address-select pins set the slave address, 64 values possible.
// - serial clock up to 1 MHz; the master runs at 6.25 MHz, 160 ns per bit.
// - serial clock and data glitches are filtered before protocol logic.
module gex_expander (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe,
    input  wire logic [1:0]  i_addr_select_pin_0,
    input  wire logic [1:0]  i_addr_select_pin_1,
    input  wire logic [1:0]  i_addr_select_pin_2,
    input  wire logic [15:0] i_bank_pin,
    output logic      [15:0] o_bank_pin,
    output logic      [15:0] o_bank_pin_oe,
    output logic             o_change_alert_n,
    output logic             o_change_alert_n_oe,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic [31:0]      o_hrdata,
    output logic             o_hresp,
    output logic             o_irq
);
    typedef struct packed {
        logic [15:0]          drive;
        logic [15:0]          outv;
        logic [15:0]          pol;
        logic [15:0]          held;
        logic                 armed;
        logic [1:0]           stat;
        logic [1:0]           mask;
        logic                 irq;
        logic                 alert;
        logic                 scl_p;
        logic                 sda_p;
        gex_pkg::gex_i2c_st_t st;
        logic [3:0]           cnt;
        logic [7:0]           sh;
        logic                 rw;
        logic                 first;
        logic [2:0]           ptr;
        logic                 sda_oe;
        logic                 a_wr;
        logic [5:0]           a_adr;
        logic [31:0]          rdata;
    } gex_state_t;

    localparam gex_state_t ST_RST = '{
        drive: gex_pkg::RST_DRIVE, outv: gex_pkg::RST_OUT, pol: gex_pkg::RST_POL,
        held: 16'h0000, armed: 1'b0, stat: 2'h0, mask: 2'h0, irq: 1'b0,
        alert: 1'b0, scl_p: 1'b1, sda_p: 1'b1, st: gex_pkg::GEX_IDLE,
        cnt: 4'h0, sh: 8'h00, rw: 1'b0, first: 1'b0, ptr: 3'h0, sda_oe: 1'b0,
        a_wr: 1'b0, a_adr: 6'h00, rdata: 32'h0000_0000};

    gex_state_t  s_q;
    gex_state_t  s_d;
    logic [21:0] pin_sync;
    logic [15:0] live;
    logic [6:0]  my_addr;
    logic        scl_f;
    logic        sda_f;

    // ==========================================================
    // input synchronisers and line filters
    gex_sync #(.W(22)) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_addr_select_pin_2, i_addr_select_pin_1,
                     i_addr_select_pin_0, i_bank_pin}),
        .o_sync    (pin_sync)
    );

    gex_glitch_filt u_filt_scl (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_line    (i_scl),
        .o_line    (scl_f)
    );

    gex_glitch_filt u_filt_sda (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_line    (i_sda),
        .o_line    (sda_f)
    );

    assign live    = pin_sync[15:0];
    assign my_addr = {gex_pkg::ADDR_TOP, pin_sync[21:16]};

    // ==========================================================
    // register read and write helpers
    function automatic logic [7:0] rd_reg(input gex_state_t s, input logic [15:0] lv,
                                          input logic [2:0] idx);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            gex_pkg::REG_IN0:  r = lv[7:0] ^ s.pol[7:0];
            gex_pkg::REG_IN1:  r = lv[15:8] ^ s.pol[15:8];
            gex_pkg::REG_OUT0: r = s.outv[7:0];
            gex_pkg::REG_OUT1: r = s.outv[15:8];
            gex_pkg::REG_POL0: r = s.pol[7:0];
            gex_pkg::REG_POL1: r = s.pol[15:8];
            gex_pkg::REG_CFG0: r = ~s.drive[7:0];
            gex_pkg::REG_CFG1: r = ~s.drive[15:8];
            default:           r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic gex_state_t wr_reg(input gex_state_t s, input logic [2:0] idx,
                                          input logic [7:0] d);
        gex_state_t r;
        r = s;
        case (idx)
            gex_pkg::REG_OUT0: r.outv[7:0]   = d;
            gex_pkg::REG_OUT1: r.outv[15:8]  = d;
            gex_pkg::REG_POL0: r.pol[7:0]    = d;
            gex_pkg::REG_POL1: r.pol[15:8]   = d;
            gex_pkg::REG_CFG0: r.drive[7:0]  = ~d;
            gex_pkg::REG_CFG1: r.drive[15:8] = ~d;
            default:           r = s;
        endcase
        return r;
    endfunction

    // ==========================================================
    // next state
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       load_tx;
    logic       wr_evt;
    logic       chg;
    logic [1:0] snap;
    logic [1:0] clr;
    logic [7:0] tx_byte;

    always_comb begin
        s_d      = s_q;
        scl_rise = scl_f & ~s_q.scl_p;
        scl_fall = ~scl_f & s_q.scl_p;
        start_c  = scl_f & s_q.scl_p & s_q.sda_p & ~sda_f;
        stop_c   = scl_f & s_q.scl_p & ~s_q.sda_p & sda_f;
        load_tx  = 1'b0;
        wr_evt   = 1'b0;
        snap     = 2'h0;
        clr      = 2'h0;
        tx_byte  = 8'h00;
        s_d.scl_p = scl_f;
        s_d.sda_p = sda_f;
        s_d.a_wr  = 1'b0;

        // serial slave
        if (start_c) begin
            s_d.st     = gex_pkg::GEX_ADDR;
            s_d.cnt    = 4'h0;
            s_d.sda_oe = 1'b0;
        end else if (stop_c) begin
            s_d.st     = gex_pkg::GEX_IDLE;
            s_d.sda_oe = 1'b0;
        end else begin
            case (s_q.st)
                gex_pkg::GEX_ADDR, gex_pkg::GEX_RX: begin
                    if (scl_rise) begin
                        s_d.sh  = {s_q.sh[6:0], sda_f};
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (scl_fall && s_q.cnt == 4'h8) begin
                        if (s_q.st == gex_pkg::GEX_ADDR) begin
                            if (s_q.sh[7:1] == my_addr) begin
                                s_d.sda_oe = 1'b1;
                                s_d.rw     = s_q.sh[0];
                                s_d.first  = ~s_q.sh[0];
                                s_d.st     = gex_pkg::GEX_ACK;
                            end else begin
                                s_d.st = gex_pkg::GEX_IDLE;
                            end
                        end else begin
                            if (s_q.first) begin
                                s_d.ptr   = s_q.sh[2:0];
                                s_d.first = 1'b0;
                            end else begin
                                s_d       = wr_reg(s_d, s_q.ptr, s_q.sh);
                                s_d.ptr   = {s_q.ptr[2:1], ~s_q.ptr[0]};
                                wr_evt    = 1'b1;
                            end
                            s_d.sda_oe = 1'b1;
                            s_d.st     = gex_pkg::GEX_ACK;
                        end
                    end
                end
                gex_pkg::GEX_ACK: begin
                    if (scl_fall) begin
                        s_d.cnt = 4'h0;
                        if (s_q.rw) begin
                            load_tx = 1'b1;
                        end else begin
                            s_d.sda_oe = 1'b0;
                            s_d.st     = gex_pkg::GEX_RX;
                        end
                    end
                end
                gex_pkg::GEX_TX: begin
                    if (scl_fall) begin
                        if (s_q.cnt == 4'h8) begin
                            s_d.sda_oe = 1'b0;
                            s_d.st     = gex_pkg::GEX_MACK;
                        end else begin
                            s_d.sh     = {s_q.sh[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.sh[6];
                            s_d.cnt    = s_q.cnt + 4'h1;
                        end
                    end
                end
                gex_pkg::GEX_MACK: begin
                    if (scl_rise && sda_f) begin
                        s_d.st = gex_pkg::GEX_IDLE;
                    end else if (scl_fall) begin
                        load_tx = 1'b1;
                    end
                end
                gex_pkg::GEX_IDLE: begin
                    s_d.sda_oe = 1'b0;
                end
                default: begin
                    s_d.st     = gex_pkg::GEX_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end

        if (load_tx) begin
            tx_byte    = rd_reg(s_q, live, s_q.ptr);
            s_d.sh     = tx_byte;
            s_d.sda_oe = ~tx_byte[7];
            s_d.cnt    = 4'h1;
            s_d.ptr    = {s_q.ptr[2:1], ~s_q.ptr[0]};
            s_d.st     = gex_pkg::GEX_TX;
            snap[0]    = (s_q.ptr == gex_pkg::REG_IN0);
            snap[1]    = (s_q.ptr == gex_pkg::REG_IN1);
        end

        // bus data phase, applied after serial writes so it wins a tie
        if (s_q.a_wr) begin
            if (s_q.a_adr[5:3] == 3'h0) begin
                s_d = wr_reg(s_d, s_q.a_adr[2:0], i_hwdata[7:0]);
            end else if (s_q.a_adr == gex_pkg::WIDX_STAT) begin
                clr = i_hwdata[1:0];
            end else if (s_q.a_adr == gex_pkg::WIDX_MASK) begin
                s_d.mask = i_hwdata[1:0];
            end
        end

        // bus address phase, register read data sampled after any write above; status and mask reads use the old value
        if (i_hsel && i_htrans[1] && i_hready) begin
            s_d.a_wr  = i_hwrite;
            s_d.a_adr = i_haddr[7:2];
            if (!i_hwrite) begin
                if (i_haddr[7:5] == 3'h0) begin
                    s_d.rdata = {24'h000000, rd_reg(s_d, live, i_haddr[4:2])};
                    snap[0]   = snap[0] | (i_haddr[4:2] == gex_pkg::REG_IN0);
                    snap[1]   = snap[1] | (i_haddr[4:2] == gex_pkg::REG_IN1);
                end else if (i_haddr[7:2] == gex_pkg::WIDX_STAT) begin
                    s_d.rdata = {30'h00000000, s_q.stat};
                end else if (i_haddr[7:2] == gex_pkg::WIDX_MASK) begin
                    s_d.rdata = {30'h00000000, s_q.mask};
                end else begin
                    s_d.rdata = 32'h0000_0000;
                end
            end
        end

        // held input value, refreshed by reads and at start-up
        if (!s_q.armed) begin
            s_d.held  = live;
            s_d.armed = 1'b1;
        end
        if (snap[0]) begin
            s_d.held[7:0] = live[7:0];
        end
        if (snap[1]) begin
            s_d.held[15:8] = live[15:8];
        end

        chg        = s_q.armed && (((live ^ s_d.held) & ~s_d.drive) != 16'h0000);
        s_d.alert  = chg;
        s_d.stat   = (s_q.stat & ~clr) | {wr_evt, chg};
        s_d.irq    = (s_d.stat & s_d.mask) != 2'h0;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign o_bank_pin          = s_q.outv;
    assign o_bank_pin_oe       = s_q.drive;
    assign o_change_alert_n    = 1'b0;
    assign o_change_alert_n_oe = s_q.alert;
    assign o_sda               = 1'b0;
    assign o_sda_oe            = s_q.sda_oe;
    assign o_hreadyout         = 1'b1;
    assign o_hrdata            = s_q.rdata;
    assign o_hresp             = 1'b0;
    assign o_irq               = s_q.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence ahb_wr_s(logic [5:0] idx);
        i_hsel && i_htrans[1] && i_hready && i_hwrite && i_haddr[7:2] == idx;
    endsequence

    sequence ahb_rd_s(logic [5:0] idx);
        i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr[7:2] == idx;
    endsequence

    startup_input_a: assert property (!s_q.armed |-> o_bank_pin_oe == 16'h0000)
        else $error("pins not all inputs after reset");

    out_drive_a: assert property ((ahb_wr_s(6'h02) ##1 1'b1)
                                  |=> o_bank_pin[7:0] == $past(i_hwdata[7:0]))
        else $error("output pins do not follow written output register");

    dir_write_a: assert property ((ahb_wr_s(6'h06) ##1 1'b1)
                                  |=> o_bank_pin_oe[7:0] == ~$past(i_hwdata[7:0]))
        else $error("pin directions do not follow written direction bits");

    pol_read_a: assert property (ahb_rd_s(6'h00) && !s_q.a_wr
                                 |=> o_hrdata[7:0] == $past(live[7:0] ^ s_q.pol[7:0]))
        else $error("input read ignores polarity inversion");

    pol_readback_a: assert property (ahb_rd_s(6'h05) && !s_q.a_wr
                                     |=> o_hrdata == {24'h000000, $past(s_q.pol[15:8])})
        else $error("polarity register does not read back");

    alert_set_a: assert property (s_q.armed
                                  && ((live ^ s_q.held) & ~s_q.drive & ~s_d.drive) != 16'h0000
                                  && snap == 2'h0 |=> o_change_alert_n_oe)
        else $error("alert missing while an input differs");

    alert_release_a: assert property (o_change_alert_n_oe
                                      && ((live ^ s_q.held) & ~(s_q.drive & s_d.drive)) == 16'h0
                                      && $stable(live) |=> !o_change_alert_n_oe)
        else $error("alert stuck after inputs returned");

    alert_od_a: assert property (o_change_alert_n_oe |-> !o_change_alert_n)
        else $error("alert driven high");

    addr_ack_a: assert property (s_q.st == gex_pkg::GEX_ADDR && scl_fall && !start_c
                                 && !stop_c && s_q.cnt == 4'h8 && s_q.sh[7:1] == my_addr
                                 |=> o_sda_oe ##1 s_q.st == gex_pkg::GEX_ACK)
        else $error("own address not acknowledged");
endmodule // gex_expander

// ==== gex_i2c_host.sv ====
`timescale 1ns/10ps
module gex_i2c_host (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    // ==========================================================
    // serial master model, quarter bit of 40 ns
    localparam int QTR_NS = 40;

    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // ==========================================================
    // bus conditions and bits
    task automatic start_c();
        o_scl = 1'b0;
        #(QTR_NS);
        o_sda_low = 1'b0;
        #(QTR_NS);
        o_scl = 1'b1;
        #(2*QTR_NS);
        o_sda_low = 1'b1;
        #(2*QTR_NS);
    endtask

    task automatic glitch_c();
        o_scl = 1'b0;
        #16;
        o_scl = 1'b1;
        #(2*QTR_NS);
    endtask

    task automatic bit_c(input logic b, output logic s);
        o_scl = 1'b0;
        #(QTR_NS);
        o_sda_low = ~b;
        #(QTR_NS);
        o_scl = 1'b1;
        #(QTR_NS);
        s = i_sda;
        #(QTR_NS);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(b[i], s);
        end
        bit_c(1'b1, ack);
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            b[i] = s;
        end
        bit_c(last, s);
    endtask

    task automatic stop_c();
        o_scl = 1'b0;
        #(QTR_NS);
        o_sda_low = 1'b1;
        #(QTR_NS);
        o_scl = 1'b1;
        #(2*QTR_NS);
        o_sda_low = 1'b0;
        #(2*QTR_NS);
    endtask
endmodule // gex_i2c_host

// ==== i2c_gpio_expander_16bit_bench.sv ====
`timescale 1ns/10ps
module i2c_gpio_expander_16bit_bench;
    // ==========================================================
    // signals
    logic        i_clk = 1'b0;
    logic        i_sys_rst;
    logic        hsel, hwrite, hresp, hreadyout, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, asel0, asel1, asel2;
    logic [2:0]  hsize, acks;
    logic [15:0] pins, pin_out, pin_oe, rx;
    logic        scl, sda_low, sda_oe, sda_val, sda_line, alert_n, alert_oe;
    int          n_errors, samples_checked;

    assign sda_line = ~(sda_oe | sda_low);
    always #4 i_clk = ~i_clk;

    gex_expander dut_u (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda_line),
        .o_sda(sda_val), .o_sda_oe(sda_oe), .i_addr_select_pin_0(asel0),
        .i_addr_select_pin_1(asel1), .i_addr_select_pin_2(asel2), .i_bank_pin(pins),
        .o_bank_pin(pin_out), .o_bank_pin_oe(pin_oe), .o_change_alert_n(alert_n),
        .o_change_alert_n_oe(alert_oe), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hrdata(hrdata),
        .o_hresp(hresp), .o_irq(irq));

    gex_i2c_host pm_u (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda_line));

    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic end_test(input string name);
        $display("test %s finished, errors so far %0d", name, n_errors);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog
    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        close_out();
    end

    // ==========================================================
    // tests
    initial begin
        i_sys_rst = 1'b1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        pins = 16'h0000;
        asel0 = 2'h1;
        asel1 = 2'h2;
        asel2 = 2'h3;
        n_errors = 0;
        samples_checked = 0;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        settle(12);
        // reset state
        chk("pin_oe", 32'(pin_oe), 32'h0);
        chk("alert_oe", 32'(alert_oe), 32'h0);
        chk("alert_level", 32'(alert_n), 32'h0);
        chk("hresp_okay", 32'(hresp), 32'h0);
        chk("sda_idle", 32'(sda_oe), 32'h0);
        chk("sda_level", 32'(sda_val), 32'h0);
        for (int i = 2; i < 8; i++) begin
            rd_chk("reset_reg", 32'(i*4), (i == 4 || i == 5) ? 32'h0 : 32'hFF);
        end
        rd_chk("mask_reset", 32'h24, 32'h0);
        end_test("reset");
        // direction and output
        ahb(1'b1, 32'h18, 32'h0F);
        ahb(1'b1, 32'h08, 32'hA5);
        settle(2);
        chk("pin_oe", 32'(pin_oe), 32'h00F0);
        chk("pin_out0", 32'(pin_out[7:0]), 32'hA5);
        rd_chk("cfg0", 32'h18, 32'h0F);
        rd_chk("out0", 32'h08, 32'hA5);
        end_test("direction");
        // change alert and interrupt
        pins <= 16'h3C00;
        settle(4);
        chk("alert_set", 32'(alert_oe), 32'h1);
        rd_chk("status", 32'h20, 32'h1);
        chk("irq_masked", 32'(irq), 32'h0);
        ahb(1'b1, 32'h24, 32'h1);
        settle(2);
        chk("irq_on", 32'(irq), 32'h1);
        rd_chk("in1", 32'h04, 32'h3C);
        settle(2);
        chk("alert_read_clr", 32'(alert_oe), 32'h0);
        ahb(1'b1, 32'h20, 32'h1);
        settle(2);
        chk("irq_w1c", 32'(irq), 32'h0);
        pins <= 16'h3D00;
        settle(4);
        chk("alert_again", 32'(alert_oe), 32'h1);
        pins <= 16'h3C00;
        settle(4);
        chk("alert_return", 32'(alert_oe), 32'h0);
        ahb(1'b1, 32'h24, 32'h0);
        settle(2);
        chk("irq_mask_off", 32'(irq), 32'h0);
        ahb(1'b1, 32'h20, 32'h1);
        ahb(1'b1, 32'h14, 32'hFF);
        rd_chk("in1_inverted", 32'h04, 32'hC3);
        rd_chk("pol1_back", 32'h14, 32'hFF);
        end_test("alert");
        // refused accesses
        rd_chk("unmapped", 32'h40, 32'h0);
        ahb(1'b1, 32'h00, 32'hFF);
        rd_chk("in0_ro", 32'h00, 32'h0);
        end_test("refused");
        // serial link
        settle(1);
        pm_u.glitch_c();
        pm_u.start_c();
        pm_u.send_byte(8'h74, acks[0]);
        pm_u.stop_c();
        chk("foreign_addr_nack", 32'(acks[0]), 32'h1);
        pm_u.glitch_c();
        pm_u.start_c();
        pm_u.send_byte(8'h72, acks[2]);
        pm_u.send_byte(8'h03, acks[1]);
        pm_u.send_byte(8'h5A, acks[0]);
        pm_u.stop_c();
        chk("own_addr_acks", 32'(acks), 32'h0);
        settle(4);
        chk("pin_out1", 32'(pin_out[15:8]), 32'h5A);
        rd_chk("out1", 32'h0C, 32'h5A);
        settle(1);
        pm_u.start_c();
        pm_u.send_byte(8'h72, acks[2]);
        pm_u.send_byte(8'h03, acks[1]);
        pm_u.start_c();
        pm_u.send_byte(8'h73, acks[0]);
        pm_u.recv_byte(1'b0, rx[7:0]);
        pm_u.recv_byte(1'b1, rx[15:8]);
        pm_u.stop_c();
        chk("read_acks", 32'(acks), 32'h0);
        chk("serial_read", 32'(rx), 32'hA55A);
        ahb(1'b0, 32'h20, 32'h0);
        chk("serial_done", rd & 32'h2, 32'h2);
        end_test("serial");
        close_out();
    end
endmodule // i2c_gpio_expander_16bit_bench
